/* File: hdl/addressing_mode_decoder.sv */
// operand fetch sequencer and effective address former for the 8-bit core
`timescale 1ns/100ps
module addressing_mode_decoder (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire amd_pkg::addr_mode_t mode_i,
   input wire amd_pkg::mask_op_t mask_op_i,
   input wire logic use_second_index_i,
   input wire logic [7:0] index_first_i,
   input wire logic [7:0] index_second_i,
   input wire logic byte_valid_i,
   input wire logic [7:0] byte_i,
   input wire logic mem_valid_i,
   input wire logic [7:0] mem_data_i,
   output logic fetch_req_o,
   output logic mem_req_o,
   output logic [15:0] mem_addr_o,
   output logic done_o,
   output logic [15:0] ea_o,
   output logic [7:0] imm_o,
   output logic imm_valid_o,
   output logic [2:0] length_o,
   output logic [1:0] int_mask_o,
   output logic busy_o
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FETCH_HI,
      ST_FETCH_LO,
      ST_PTR_HI,
      ST_PTR_LO,
      ST_DONE
   } fsm_t;

   typedef struct packed {
      fsm_t st;
      amd_pkg::addr_mode_t mode;
      logic [7:0] index;
      logic [15:0] word;
      logic [7:0] ptr_addr;
      logic fetch_req;
      logic mem_req;
      logic [15:0] mem_addr;
      logic done;
      logic [15:0] ea;
      logic [7:0] imm;
      logic imm_valid;
      logic [2:0] length;
      logic [1:0] int_mask;
      logic busy;
   } state_t;

   state_t s_q;
   state_t s_d;
   logic [2:0] len_w;
   logic [1:0] ops_w;
   logic [15:0] idx_sum_w;

   amd_length u_len (
      .mode_i(mode_i),
      .length_o(len_w),
      .operand_bytes_o(ops_w)
   );

   amd_addr_calc u_calc (
      .index_i(s_q.index),
      .offset_i(s_q.word),
      .ea_o(idx_sum_w)
   );

   // finish: publish address, immediate or nothing depending on mode
   function automatic state_t finish(input state_t s, input logic [15:0] word, input logic [15:0] sum);
      state_t r;
      r = s;
      r.st = ST_DONE;
      r.done = 1'b1;
      r.busy = 1'b0;
      r.fetch_req = 1'b0;
      r.mem_req = 1'b0;
      unique case (s.mode)
         amd_pkg::MODE_IMMEDIATE: begin
            r.imm = word[7:0];
            r.imm_valid = 1'b1;
         end
         amd_pkg::MODE_DIRECT_SHORT: r.ea = {8'h00, word[7:0]};
         amd_pkg::MODE_DIRECT_LONG: r.ea = word;
         amd_pkg::MODE_INDEXED_NONE,
         amd_pkg::MODE_INDEXED_SHORT,
         amd_pkg::MODE_INDEXED_LONG: r.ea = sum;
         amd_pkg::MODE_INDIRECT_SHORT: r.ea = {8'h00, word[7:0]};
         amd_pkg::MODE_INDIRECT_LONG: r.ea = word;
         default: r.ea = amd_pkg::ADDR_RESET; // inherent has no operand address
      endcase
      return r;
   endfunction

   // sequencer; operand bytes land in word, high byte first
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      unique case (s_q.st)
         ST_IDLE, ST_DONE: begin
            s_d.st = ST_IDLE;
            s_d.busy = 1'b0;
            if (start_i) begin
               s_d.mode = mode_i;
               s_d.index = use_second_index_i ? index_second_i : index_first_i;
               s_d.word = amd_pkg::ADDR_RESET;
               s_d.length = len_w;
               s_d.imm_valid = 1'b0;
               s_d.busy = 1'b1;
               // mask change takes effect at the start of the instruction
               if (mask_op_i == amd_pkg::MASK_OP_SET) begin
                  s_d.int_mask = amd_pkg::MASK_LEVEL_SET;
               end else if (mask_op_i == amd_pkg::MASK_OP_CLEAR) begin
                  s_d.int_mask = amd_pkg::MASK_LEVEL_CLEAR;
               end
               if (ops_w == 2'h0) begin
                  s_d.st = ST_DONE;
                  s_d.done = 1'b1;
                  s_d.busy = 1'b0;
                  s_d.ea = (mode_i == amd_pkg::MODE_INDEXED_NONE) ? {8'h00, s_d.index} : amd_pkg::ADDR_RESET;
               end else begin
                  s_d.st = (ops_w == 2'h2) ? ST_FETCH_HI : ST_FETCH_LO;
                  s_d.fetch_req = 1'b1;
               end
            end
         end
         ST_FETCH_HI: begin
            if (byte_valid_i) begin
               s_d.word[15:8] = byte_i;
               s_d.st = ST_FETCH_LO;
            end
         end
         ST_FETCH_LO: begin
            if (byte_valid_i) begin
               s_d.word[7:0] = byte_i;
               s_d.fetch_req = 1'b0;
               if (s_q.mode == amd_pkg::MODE_INDIRECT_SHORT || s_q.mode == amd_pkg::MODE_INDIRECT_LONG) begin
                  s_d.ptr_addr = byte_i;
                  s_d.mem_req = 1'b1;
                  s_d.mem_addr = {8'h00, byte_i};
                  s_d.word = amd_pkg::ADDR_RESET;
                  s_d.st = (s_q.mode == amd_pkg::MODE_INDIRECT_LONG) ? ST_PTR_HI : ST_PTR_LO;
               end else begin
                  s_d.st = ST_DONE;
               end
            end
         end
         ST_PTR_HI: begin
            if (mem_valid_i) begin
               s_d.word[15:8] = mem_data_i;
               s_d.mem_addr = {8'h00, 8'(s_q.ptr_addr + 8'h01)};
               s_d.st = ST_PTR_LO;
            end
         end
         ST_PTR_LO: begin
            if (mem_valid_i) begin
               s_d.word[7:0] = mem_data_i;
               s_d.mem_req = 1'b0;
               s_d.st = ST_DONE;
            end
         end
         default: s_d.st = ST_IDLE;
      endcase
      // operand complete: form the result one cycle later through the adder
      if (s_q.st != ST_DONE && s_d.st == ST_DONE && s_q.busy) begin
         s_d.st = ST_DONE;
      end
      if (s_q.st == ST_DONE && s_q.busy) begin
         s_d = finish(s_q, s_q.word, idx_sum_w);
      end
   end

   // s_d.busy stays set through the extra adder cycle for fetched modes
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '{st: ST_IDLE, mode: amd_pkg::MODE_INHERENT, index: amd_pkg::BYTE_RESET,
                  word: amd_pkg::ADDR_RESET, ptr_addr: amd_pkg::BYTE_RESET, fetch_req: 1'b0,
                  mem_req: 1'b0, mem_addr: amd_pkg::ADDR_RESET, done: 1'b0, ea: amd_pkg::ADDR_RESET,
                  imm: amd_pkg::BYTE_RESET, imm_valid: 1'b0, length: amd_pkg::LEN_ONE,
                  int_mask: amd_pkg::MASK_LEVEL_RESET, busy: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign fetch_req_o = s_q.fetch_req;
   assign mem_req_o = s_q.mem_req;
   assign mem_addr_o = s_q.mem_addr;
   assign done_o = s_q.done;
   assign ea_o = s_q.ea;
   assign imm_o = s_q.imm;
   assign imm_valid_o = s_q.imm_valid;
   assign length_o = s_q.length;
   assign int_mask_o = s_q.int_mask;
   assign busy_o = s_q.busy;

   // assertions
   sequence seq_set_taken;
      start_i && !busy_o && mask_op_i == amd_pkg::MASK_OP_SET;
   endsequence

   sequence seq_clear_taken;
      start_i && !busy_o && mask_op_i == amd_pkg::MASK_OP_CLEAR;
   endsequence

   a_mask_set_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      seq_set_taken |=> int_mask_o == 2'h3) else $error("mask set did not give level 3");

   a_mask_clear_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      seq_clear_taken |=> int_mask_o == 2'h0) else $error("mask clear did not give level 0");

   a_inherent_one_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      start_i && !busy_o && mode_i == amd_pkg::MODE_INHERENT |=> done_o && length_o == 3'h1 && !fetch_req_o)
      else $error("inherent not single byte");

   a_index_none_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      start_i && !busy_o && mode_i == amd_pkg::MODE_INDEXED_NONE && !use_second_index_i
      |=> done_o && ea_o == {8'h00, $past(index_first_i)}) else $error("no offset indexed address wrong");

   a_immediate_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      start_i && !busy_o && mode_i == amd_pkg::MODE_IMMEDIATE |=> length_o == 3'h2 && fetch_req_o)
      else $error("immediate length wrong");

   a_long_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      start_i && !busy_o && (mode_i == amd_pkg::MODE_DIRECT_LONG || mode_i == amd_pkg::MODE_INDEXED_LONG)
      |=> length_o == 3'h3) else $error("long mode length wrong");

   a_short_ea_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      done_o && s_q.mode == amd_pkg::MODE_DIRECT_SHORT |-> ea_o[15:8] == 8'h00)
      else $error("short direct beyond FF");

   a_indirect_reads: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      fetch_req_o && byte_valid_i && s_q.st == ST_FETCH_LO && s_q.mode == amd_pkg::MODE_INDIRECT_SHORT
      |=> mem_req_o && mem_addr_o == {8'h00, $past(byte_i)}) else $error("pointer not read at operand");

   // a zero-operand start taken in the done cycle legally gives a second done
   a_done_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      done_o && !(start_i && (mode_i == amd_pkg::MODE_INHERENT || mode_i == amd_pkg::MODE_INDEXED_NONE))
      |=> !done_o) else $error("done longer than one cycle");

   // operand byte and pointer byte steps
   sequence seq_word_hi_taken;
      s_q.st == ST_FETCH_HI && byte_valid_i;
   endsequence

   sequence seq_ptr_hi_taken;
      s_q.st == ST_PTR_HI && mem_valid_i;
   endsequence

   a_hi_byte_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      seq_word_hi_taken |=> s_q.word[15:8] == $past(byte_i) && s_q.st == ST_FETCH_LO)
      else $error("first operand byte not taken as high byte");

   a_lo_byte_last: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_q.st == ST_FETCH_LO && byte_valid_i && s_q.mode != amd_pkg::MODE_INDIRECT_SHORT
      && s_q.mode != amd_pkg::MODE_INDIRECT_LONG |=> s_q.word[7:0] == $past(byte_i) && !fetch_req_o)
      else $error("last operand byte not taken");

   a_short_fetch_one: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      start_i && !busy_o && mode_i == amd_pkg::MODE_DIRECT_SHORT |=> s_q.st == ST_FETCH_LO && fetch_req_o)
      else $error("short direct does not fetch one byte");

   a_second_index_sel: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      start_i && !busy_o && use_second_index_i |=> s_q.index == $past(index_second_i))
      else $error("second index register not selected");

   a_index_short_sum: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      done_o && s_q.mode == amd_pkg::MODE_INDEXED_SHORT |-> ea_o <= 16'h01FE
      && ea_o == 16'({8'h00, s_q.index} + {8'h00, s_q.word[7:0]})) else $error("short indexed address wrong");

   a_index_long_sum: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      done_o && s_q.mode == amd_pkg::MODE_INDEXED_LONG
      |-> ea_o == 16'({9'h000, s_q.index} + {1'h0, s_q.word})) else $error("long indexed address wrong");

   a_ptr_next_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      seq_ptr_hi_taken |=> mem_req_o && mem_addr_o == {8'h00, 8'(s_q.ptr_addr + 8'h01)})
      else $error("low pointer byte not read at next address");

   a_ptr_hi_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      seq_ptr_hi_taken |=> s_q.word[15:8] == $past(mem_data_i) && s_q.st == ST_PTR_LO)
      else $error("first pointer byte not taken as high byte");

   a_indirect_short_ea: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      done_o && s_q.mode == amd_pkg::MODE_INDIRECT_SHORT |-> ea_o[15:8] == 8'h00)
      else $error("short indirect beyond FF");

   a_mask_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !(start_i && !busy_o && mask_op_i != amd_pkg::MASK_OP_NONE) |=> $stable(int_mask_o))
      else $error("mask level changed without a mask instruction");
endmodule // addressing_mode_decoder

/* File: hdl/amd_pkg.sv */
// constants and types shared by the addressing mode decoder
package amd_pkg;
   typedef enum logic [3:0] {
      MODE_INHERENT,
      MODE_IMMEDIATE,
      MODE_DIRECT_SHORT,
      MODE_DIRECT_LONG,
      MODE_INDEXED_NONE,
      MODE_INDEXED_SHORT,
      MODE_INDEXED_LONG,
      MODE_INDIRECT_SHORT,
      MODE_INDIRECT_LONG
   } addr_mode_t;

   typedef enum logic [1:0] {
      MASK_OP_NONE,
      MASK_OP_SET,
      MASK_OP_CLEAR
   } mask_op_t;

   localparam logic [1:0] MASK_LEVEL_SET = 2'h3;
   localparam logic [1:0] MASK_LEVEL_CLEAR = 2'h0;
   localparam logic [1:0] MASK_LEVEL_RESET = 2'h3;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [2:0] LEN_ONE = 3'h1;
   localparam logic [2:0] LEN_TWO = 3'h2;
   localparam logic [2:0] LEN_THREE = 3'h3;
endpackage

/* File: hdl/amd_length.sv */
// instruction length and operand byte count per addressing mode
`timescale 1ns/100ps
module amd_length (
   input wire amd_pkg::addr_mode_t mode_i,
   output logic [2:0] length_o,
   output logic [1:0] operand_bytes_o
);
   // operand bytes after the opcode; length is that plus the opcode
   always_comb begin
      unique case (mode_i)
         amd_pkg::MODE_INHERENT,
         amd_pkg::MODE_INDEXED_NONE: begin
            length_o = amd_pkg::LEN_ONE;
         end
         amd_pkg::MODE_DIRECT_LONG,
         amd_pkg::MODE_INDEXED_LONG: begin
            length_o = amd_pkg::LEN_THREE;
         end
         default: begin
            length_o = amd_pkg::LEN_TWO;
         end
      endcase
      operand_bytes_o = 2'(length_o - amd_pkg::LEN_ONE);
   end
endmodule // amd_length

/* File: hdl/amd_addr_calc.sv */
// effective address arithmetic for the indexed modes
`timescale 1ns/100ps
module amd_addr_calc (
   input wire logic [7:0] index_i,
   input wire logic [15:0] offset_i,
   output logic [15:0] ea_o
);
   // unsigned add, carry above bit 15 discarded to stay in 64 Kbyte
   always_comb begin
      logic [16:0] sum;
      sum = {9'h000, index_i} + {1'h0, offset_i};
      ea_o = sum[15:0];
   end
endmodule // amd_addr_calc

/* File: verification/amd_partner.sv */
// fetch path and data memory model facing the decoder
`timescale 1ns/100ps
module amd_partner (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic slow_i,
   input wire logic [15:0] op_word_i,
   input wire logic fetch_req_i,
   input wire logic mem_req_i,
   input wire logic [15:0] mem_addr_i,
   output logic byte_valid_o,
   output logic [7:0] byte_o,
   output logic mem_valid_o,
   output logic [7:0] mem_data_o
);
   logic [1:0] idx;
   logic [2:0] gap;
   // changes at falling edge; a byte is offered for one rising edge only
   always @(negedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         byte_valid_o = 1'b0;
         mem_valid_o = 1'b0;
         byte_o = 8'h00;
         mem_data_o = 8'h00;
         idx = 2'h0;
         gap = 3'h0;
      end else if (byte_valid_o) begin
         byte_valid_o = 1'b0;
         byte_o = ~byte_o; // stale data never looks valid
         idx = idx + 2'h1;
      end else if (mem_valid_o) begin
         mem_valid_o = 1'b0;
         mem_data_o = ~mem_data_o;
      end else if (gap != 3'h0) begin
         gap = gap - 3'h1; // slow answer
      end else if (fetch_req_i) begin
         byte_valid_o = 1'b1;
         byte_o = (idx == 2'h0) ? op_word_i[15:8] : op_word_i[7:0];
         gap = slow_i ? 3'h3 : 3'h0;
      end else if (mem_req_i) begin
         mem_valid_o = 1'b1;
         mem_data_o = mem_addr_i[7:0] ^ 8'h5A;
         gap = slow_i ? 3'h3 : 3'h0;
      end
      if (!fetch_req_i) begin
         idx = 2'h0;
      end
   end
endmodule // amd_partner

/* File: verification/tb_top.sv */
// self-checking bench for the addressing mode decoder
`timescale 1ns/100ps
module tb_top;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic start_i = 1'b0;
   amd_pkg::addr_mode_t mode_i = amd_pkg::MODE_INHERENT;
   amd_pkg::mask_op_t mask_op_i = amd_pkg::MASK_OP_NONE;
   logic use_second_index_i = 1'b0;
   logic [7:0] index_first_i = 8'h00;
   logic [7:0] index_second_i = 8'h00;
   logic byte_valid_i, mem_valid_i, fetch_req_o, mem_req_o, done_o, imm_valid_o, busy_o;
   logic [7:0] byte_i, mem_data_i, imm_o;
   logic [15:0] mem_addr_o, ea_o;
   logic [2:0] length_o;
   logic [1:0] int_mask_o;
   logic slow = 1'b0;
   logic [15:0] op_word = 16'h0000;
   int err_total = 0;
   int num_checks = 0;
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   addressing_mode_decoder i_addressing_mode_decoder (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i),
      .mode_i(mode_i), .mask_op_i(mask_op_i), .use_second_index_i(use_second_index_i),
      .index_first_i(index_first_i), .index_second_i(index_second_i), .byte_valid_i(byte_valid_i),
      .byte_i(byte_i), .mem_valid_i(mem_valid_i), .mem_data_i(mem_data_i), .fetch_req_o(fetch_req_o),
      .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .done_o(done_o), .ea_o(ea_o), .imm_o(imm_o),
      .imm_valid_o(imm_valid_o), .length_o(length_o), .int_mask_o(int_mask_o), .busy_o(busy_o));
   amd_partner i_amd_partner (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow), .op_word_i(op_word),
      .fetch_req_i(fetch_req_o), .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o), .byte_valid_o(byte_valid_i),
      .byte_o(byte_i), .mem_valid_o(mem_valid_i), .mem_data_o(mem_data_i));
   task automatic summarize();
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one instruction; ea compared only where the mode forms one
   task automatic decode(input amd_pkg::addr_mode_t m, input amd_pkg::mask_op_t k, input logic sec,
         input logic [7:0] x, input logic [7:0] y, input logic [15:0] w, input logic [2:0] len,
         input logic chk_ea, input logic [15:0] ea);
      int n;
      @(negedge clk_i);
      mode_i = m;
      mask_op_i = k;
      use_second_index_i = sec;
      index_first_i = x;
      index_second_i = y;
      op_word = w;
      start_i = 1'b1;
      @(negedge clk_i);
      start_i = 1'b0;
      n = 0;
      while (done_o !== 1'b1 && n < 60) begin
         @(negedge clk_i);
         n++;
      end
      if (n == 60) begin
         err_total++;
         summarize();
      end
      check(16'(length_o), 16'(len));
      if (chk_ea) begin
         check(ea_o, ea);
      end
   endtask
   task automatic t_inherent_mask();
      decode(amd_pkg::MODE_INHERENT, amd_pkg::MASK_OP_CLEAR, 1'b0, 8'h00, 8'h00, 16'h0000, 3'h1, 1'b0, 16'h0);
      check(16'(int_mask_o), 16'h0000);
      decode(amd_pkg::MODE_INHERENT, amd_pkg::MASK_OP_SET, 1'b0, 8'h00, 8'h00, 16'h0000, 3'h1, 1'b0, 16'h0);
      check(16'(int_mask_o), 16'h0003);
   endtask
   task automatic t_immediate();
      decode(amd_pkg::MODE_IMMEDIATE, amd_pkg::MASK_OP_NONE, 1'b0, 8'h00, 8'h00, 16'hC300, 3'h2, 1'b0, 16'h0);
      check(16'(imm_o), 16'h00C3);
      check(16'(imm_valid_o), 16'h0001);
      check(16'(int_mask_o), 16'h0003);
   endtask
   task automatic t_direct();
      decode(amd_pkg::MODE_DIRECT_SHORT, amd_pkg::MASK_OP_NONE, 1'b0, 8'h00, 8'h00, 16'h9A00, 3'h2, 1'b1, 16'h009A);
      check(16'(imm_valid_o), 16'h0000);
      slow = 1'b1;
      decode(amd_pkg::MODE_DIRECT_LONG, amd_pkg::MASK_OP_NONE, 1'b0, 8'h00, 8'h00, 16'h1234, 3'h3, 1'b1, 16'h1234);
      slow = 1'b0;
   endtask
   // index sums at the limits of each width
   task automatic t_indexed();
      decode(amd_pkg::MODE_INDEXED_NONE, amd_pkg::MASK_OP_NONE, 1'b0, 8'hFE, 8'h11, 16'h0000, 3'h1, 1'b1, 16'h00FE);
      decode(amd_pkg::MODE_INDEXED_NONE, amd_pkg::MASK_OP_NONE, 1'b1, 8'hFE, 8'h07, 16'h0000, 3'h1, 1'b1, 16'h0007);
      decode(amd_pkg::MODE_INDEXED_SHORT, amd_pkg::MASK_OP_NONE, 1'b1, 8'h01, 8'hFF, 16'hFF00, 3'h2, 1'b1, 16'h01FE);
      decode(amd_pkg::MODE_INDEXED_LONG, amd_pkg::MASK_OP_NONE, 1'b0, 8'h20, 8'h00, 16'hFFF0, 3'h3, 1'b1, 16'h0010);
   endtask
   // pointer at FF checks the wrap of the low pointer byte
   task automatic t_indirect();
      decode(amd_pkg::MODE_INDIRECT_SHORT, amd_pkg::MASK_OP_NONE, 1'b0, 8'h00, 8'h00, 16'h4000, 3'h2, 1'b1, 16'h001A);
      slow = 1'b1;
      decode(amd_pkg::MODE_INDIRECT_LONG, amd_pkg::MASK_OP_NONE, 1'b0, 8'h00, 8'h00, 16'hFF00, 3'h2, 1'b1, 16'hA55A);
      slow = 1'b0;
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      rst_n_i = 1'b1;
      check(16'(busy_o), 16'h0000);
      t_inherent_mask();
      t_immediate();
      t_direct();
      t_indexed();
      t_indirect();
      summarize();
   end
endmodule // tb_top
